// ---- logic/light_conversion_control.sv ----
// conversion control of an ambient light sensor: mode, integration time,
// automatic range stepping and overflow flag, behind an AXI4-Lite slave
// assumes the analog front end reports overload and mantissa on ref_clk
//
// Overview of operation
// - integration_time_sel picks 100 ms (0) or 800 ms (1); resets to 1.
// - full resolution at 800 ms, or at 100 ms with range above 0101b.
// - at 100 ms: lose one bit at 0101b, two at 0100b-0001b, three at 0000b.
// - result word layout and LSB weight never depend on integration time.
// - mode resets to shutdown; front end stays off until another mode.
// - writing single-shot starts one conversion; mode reads 01b while running.
// - end of a single-shot conversion returns mode to shutdown by itself.
// - overrange_flag shows whether the last measurement overflowed.
// - manual range: a passing overload may set the flag anyway.
// - automatic range: flag at measurement end only for overload at the highest range.
// - automatic range overload below maximum: abort, step range up, restart.
// - each automatic step sets the flag once the step is done.
// - range_select 1100b means automatic; chosen range goes to the exponent.
`timescale 1ns/1ps
module light_conversion_control
  import light_conv_pkg::*;
#(
  parameter int unsigned CYC_SHORT_P = CYC_SHORT,
  parameter int unsigned CYC_LONG_P  = CYC_LONG
)
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [AXI_SW-1:0] s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic              adc_overload,
  input  wire logic [MANT_W-1:0] adc_mantissa,
  output afe_ctrl_t              afe,
  output logic                   irq
);

  localparam logic [TMR_W-1:0] LEN_SHORT = TMR_W'(CYC_SHORT_P);
  localparam logic [TMR_W-1:0] LEN_LONG  = TMR_W'(CYC_LONG_P);

  typedef struct packed {
    logic [RANGE_W-1:0] range_select;
    logic               integration_time_sel;
    logic [MODE_W-1:0]  mode;
    logic               overrange_flag;
    conv_state_t        conv;
    logic               run_ct;
    logic               run_auto;
    logic [RANGE_W-1:0] act_range;
    logic               ovf_seen;
    logic [LOSS_W-1:0]  res_loss;
    result_t            result;
    logic               t_start;
    logic               t_abort;
    logic [TMR_W-1:0]   t_len;
    logic [IRQ_W-1:0]   irq_st;
    logic [IRQ_W-1:0]   irq_mask;
    logic               irq;
    afe_ctrl_t          afe;
    logic               aw_rdy;
    logic               aw_have;
    logic [AXI_AW-1:0]  aw_addr;
    logic               w_rdy;
    logic               w_have;
    logic [AXI_DW-1:0]  w_data;
    logic [AXI_SW-1:0]  w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               ar_rdy;
    logic               rvalid;
    logic [AXI_DW-1:0]  rdata;
    logic [1:0]         rresp;
  } ctl_state_t;

  ctl_state_t        q;
  ctl_state_t        d;
  logic              tmr_busy;
  logic              tmr_done;
  logic              wr_go;
  logic              cfg_wr;
  logic              ovl;
  logic              done_ok;
  logic              step_up;
  logic [AXI_DW-1:0] wdat;

  function automatic logic is_mapped(input logic [AXI_AW-1:0] addr);
    is_mapped = (addr == OFS_CONFIG) || (addr == OFS_RESULT) || (addr == OFS_STATUS)
             || (addr == OFS_IRQ_STAT) || (addr == OFS_IRQ_MASK);
  endfunction

  function automatic logic [AXI_DW-1:0] read_word(input logic [AXI_AW-1:0] addr,
                                                  input ctl_state_t s);
    logic [AXI_DW-1:0] w;
    w = '0;
    if (addr == OFS_CONFIG)
    begin
      w[CFG_RANGE_LSB +: RANGE_W] = s.range_select;
      w[CFG_CT_POS]               = s.integration_time_sel;
      w[CFG_MODE_LSB +: MODE_W]   = s.mode;
      w[CFG_OVF_POS]              = s.overrange_flag;
    end
    else if (addr == OFS_RESULT)
      w[RANGE_W+MANT_W-1:0] = s.result;
    else if (addr == OFS_STATUS)
    begin
      w[STAT_BUSY_POS]             = (s.conv == CONV_RUN);
      w[STAT_LOSS_LSB +: LOSS_W]   = s.res_loss;
      w[STAT_RANGE_LSB +: RANGE_W] = s.act_range;
    end
    else if (addr == OFS_IRQ_STAT)
      w[IRQ_W-1:0] = s.irq_st;
    else if (addr == OFS_IRQ_MASK)
      w[IRQ_W-1:0] = s.irq_mask;
    read_word = w;
  endfunction

  function automatic logic [AXI_DW-1:0] byte_merge(input logic [AXI_DW-1:0] old_w,
                                                   input logic [AXI_DW-1:0] new_w,
                                                   input logic [AXI_SW-1:0] strb);
    logic [AXI_DW-1:0] w;
    w = old_w;
    for (int i = 0; i < AXI_SW; i++)
      if (strb[i])
        w[i*8 +: 8] = new_w[i*8 +: 8];
    byte_merge = w;
  endfunction

  // effective resolution loss for a range and integration time
  function automatic logic [LOSS_W-1:0] res_loss_of(input logic [RANGE_W-1:0] rng,
                                                    input logic ct);
    if (ct || rng > RANGE_FULL_ABV)
      res_loss_of = LOSS_NONE;
    else if (rng == RANGE_FULL_ABV)
      res_loss_of = LOSS_ONE;
    else if (rng >= RANGE_ONE)
      res_loss_of = LOSS_TWO;
    else
      res_loss_of = LOSS_THREE;
  endfunction

  integration_timer #(
    .CNT_W (TMR_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (q.t_start),
    .abort   (q.t_abort),
    .length  (q.t_len),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // a stale done from an aborted window lands in the t_start cycle and is dropped
  assign wr_go   = q.aw_have && q.w_have && !q.bvalid;
  assign cfg_wr  = wr_go && (q.aw_addr == OFS_CONFIG);
  assign wdat    = byte_merge(read_word(q.aw_addr, q), q.w_data, q.w_strb);
  assign ovl     = adc_overload && (tmr_busy || tmr_done) && (q.conv == CONV_RUN)
                && !q.t_start;
  assign done_ok = tmr_done && (q.conv == CONV_RUN) && !q.t_start;
  assign step_up = ovl && q.run_auto && (q.act_range < RANGE_MAX);

  always_comb
  begin
    logic [IRQ_W-1:0] set;
    logic [IRQ_W-1:0] clr;
    set       = '0;
    clr       = '0;
    d         = q;
    d.t_start = 1'b0;
    d.t_abort = 1'b0;

    // write address and data are taken independently, response follows both
    if (q.aw_rdy && s_axi_awvalid)
    begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (q.w_rdy && s_axi_wvalid)
    begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (wr_go)
    begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = is_mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_go && q.aw_addr == OFS_IRQ_STAT)
      clr = wdat[IRQ_W-1:0];
    if (wr_go && q.aw_addr == OFS_IRQ_MASK)
      d.irq_mask = wdat[IRQ_W-1:0];

    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (q.ar_rdy && s_axi_arvalid)
    begin
      d.rvalid = 1'b1;
      d.rdata  = read_word(s_axi_araddr, q);
      d.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    unique case (q.conv)
      CONV_IDLE:
      begin
        // shutdown stays idle; single and continuous both start a window
        if (q.mode != MODE_SHUTDOWN)
        begin
          d.conv      = CONV_RUN;
          d.run_ct    = q.integration_time_sel;
          d.run_auto  = (q.range_select == RANGE_AUTO);
          d.act_range = d.run_auto ? RANGE_MIN
                      : (q.range_select > RANGE_MAX ? RANGE_MAX : q.range_select);
          d.ovf_seen  = 1'b0;
          d.t_start   = 1'b1;
          d.t_len     = q.integration_time_sel ? LEN_LONG : LEN_SHORT;
          d.res_loss  = res_loss_of(d.act_range, d.run_ct);
        end
      end
      CONV_RUN:
      begin
        if (step_up)
        begin
          d.act_range      = q.act_range + RANGE_ONE;
          d.overrange_flag = 1'b1;
          d.ovf_seen       = 1'b0;
          d.t_start        = 1'b1;
          d.res_loss       = res_loss_of(d.act_range, q.run_ct);
          set[IRQ_STEP]    = 1'b1;
        end
        else
        begin
          // manual: any overload counts; auto: only reached at the top range
          if (ovl)
            d.ovf_seen = 1'b1;
          if (done_ok)
          begin
            d.result.exponent = q.act_range;
            d.result.mantissa = adc_mantissa;
            d.overrange_flag  = q.ovf_seen || ovl;
            d.conv            = CONV_IDLE;
            set[IRQ_DONE]     = 1'b1;
            set[IRQ_OVF]      = d.overrange_flag;
            if (q.mode == MODE_SINGLE)
              d.mode = MODE_SHUTDOWN;
          end
        end
      end
    endcase

    // host write comes last so it wins over the automatic mode clear
    if (cfg_wr)
    begin
      d.range_select         = wdat[CFG_RANGE_LSB +: RANGE_W];
      d.integration_time_sel = wdat[CFG_CT_POS];
      d.mode                 = wdat[CFG_MODE_LSB +: MODE_W];
      if (d.mode == MODE_SHUTDOWN && d.conv == CONV_RUN)
      begin
        d.conv    = CONV_IDLE;
        d.t_start = 1'b0;
        d.t_abort = 1'b1;
      end
    end

    // set wins over a simultaneous write-one clear
    d.irq_st     = (q.irq_st & ~clr) | set;
    d.irq        = |(d.irq_st & d.irq_mask);
    d.afe.enable = (d.conv == CONV_RUN);
    d.afe.range  = d.act_range;
    d.aw_rdy     = !d.aw_have && !d.bvalid;
    d.w_rdy      = !d.w_have && !d.bvalid;
    d.ar_rdy     = !d.rvalid;

    if (!rstn)
    begin
      d                      = '0;
      d.range_select         = RANGE_RST;
      d.integration_time_sel = CT_RST;
      d.mode                 = MODE_SHUTDOWN;
      d.aw_rdy               = 1'b1;
      d.w_rdy                = 1'b1;
      d.ar_rdy               = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
    q <= d;

  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready  = q.w_rdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign afe           = q.afe;
  assign irq           = q.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_step;
    step_up && !cfg_wr;
  endsequence

  sequence s_finish;
    done_ok && !step_up;
  endsequence

  AST_CT_LENGTH: assert property (
    q.t_start |-> q.t_len == (q.run_ct ? LEN_LONG : LEN_SHORT))
    else $error("integration length does not match time select");
  AST_FULL_RES: assert property (
    q.conv == CONV_RUN && (q.run_ct || q.act_range > RANGE_FULL_ABV) |-> q.res_loss == LOSS_NONE)
    else $error("resolution loss reported where full resolution applies");
  AST_LOSS_LOWEST: assert property (
    q.conv == CONV_RUN && !q.run_ct && q.act_range == RANGE_MIN |-> q.res_loss == LOSS_THREE)
    else $error("lowest range at short time must lose three bits");
  AST_RESULT_FMT: assert property (
    s_finish |=> q.result.mantissa == $past(adc_mantissa))
    else $error("result mantissa not taken unchanged");
  AST_SHUTDOWN_OFF: assert property (
    q.mode == MODE_SHUTDOWN && q.conv == CONV_IDLE && !cfg_wr |=> !q.afe.enable[*2])
    else $error("front end enabled in shutdown");
  AST_SINGLE_HOLD: assert property (
    q.conv == CONV_RUN && q.mode == MODE_SINGLE && !done_ok && !cfg_wr
      |=> q.mode == MODE_SINGLE)
    else $error("single-shot mode lost during conversion");
  AST_SINGLE_CLEAR: assert property (
    s_finish and (q.mode == MODE_SINGLE && !cfg_wr)
      |=> q.mode == MODE_SHUTDOWN && q.conv == CONV_IDLE ##1 !q.afe.enable)
    else $error("single-shot end did not return to shutdown");
  AST_OVF_EVAL: assert property (
    s_finish |=> q.overrange_flag == $past(q.ovf_seen || ovl))
    else $error("overflow flag not re-evaluated at end of measurement");
  AST_MANUAL_OVL: assert property (
    ovl && !q.run_auto && !done_ok && !cfg_wr |=> q.ovf_seen)
    else $error("transient overload missed in manual range");
  AST_AUTO_OVF_MAX: assert property (
    q.run_auto && q.conv == CONV_RUN && !q.t_start && $rose(q.ovf_seen)
      |-> q.act_range == RANGE_MAX)
    else $error("auto overflow recorded below top range");
  AST_STEP_RANGE: assert property (
    s_step |=> q.act_range == $past(q.act_range) + RANGE_ONE && q.t_start ##1 tmr_busy)
    else $error("auto step did not raise range and restart");
  AST_STEP_FLAG: assert property (
    s_step |=> q.overrange_flag && q.irq_st[IRQ_STEP])
    else $error("flag not set after range step");
  AST_AUTO_EXP: assert property (
    s_finish |=> q.result.exponent == $past(q.act_range))
    else $error("exponent does not report the range used");
  AST_CONT_RESTART: assert property (
    q.conv == CONV_IDLE && q.mode[MODE_CONT_BIT] && !cfg_wr |=> q.conv == CONV_RUN && q.t_start)
    else $error("continuous mode did not restart");

endmodule

// ---- logic/light_conv_pkg.sv ----
// constants, field layout and carrier types of the light conversion control block
// assumes a single 250 MHz clock and an AXI4-Lite register port
package light_conv_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_MS     = 1_000_000;
  localparam int unsigned T_SHORT_MS    = 100;
  localparam int unsigned T_LONG_MS     = 800;
  localparam int unsigned CYC_SHORT     = T_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned CYC_LONG      = T_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;

  // widths
  localparam int unsigned AXI_AW  = 12;
  localparam int unsigned AXI_DW  = 32;
  localparam int unsigned AXI_SW  = AXI_DW / 8;
  localparam int unsigned TMR_W   = 32;
  localparam int unsigned MANT_W  = 12;
  localparam int unsigned RANGE_W = 4;
  localparam int unsigned MODE_W  = 2;
  localparam int unsigned LOSS_W  = 2;
  localparam int unsigned IRQ_W   = 3;

  // register byte addresses
  localparam logic [AXI_AW-1:0] OFS_CONFIG   = 12'h000;
  localparam logic [AXI_AW-1:0] OFS_RESULT   = 12'h004;
  localparam logic [AXI_AW-1:0] OFS_STATUS   = 12'h008;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STAT = 12'h00C;
  localparam logic [AXI_AW-1:0] OFS_IRQ_MASK = 12'h010;

  // field positions
  localparam int unsigned CFG_RANGE_LSB  = 12;
  localparam int unsigned CFG_CT_POS     = 11;
  localparam int unsigned CFG_MODE_LSB   = 9;
  localparam int unsigned CFG_OVF_POS    = 8;
  localparam int unsigned STAT_BUSY_POS  = 0;
  localparam int unsigned STAT_LOSS_LSB  = 4;
  localparam int unsigned STAT_RANGE_LSB = 8;
  localparam int unsigned MODE_CONT_BIT  = 1;
  localparam int unsigned IRQ_DONE       = 0;
  localparam int unsigned IRQ_OVF        = 1;
  localparam int unsigned IRQ_STEP       = 2;

  // field codes and reset values
  localparam logic [RANGE_W-1:0] RANGE_MIN      = 4'h0;
  localparam logic [RANGE_W-1:0] RANGE_ONE      = 4'h1;
  localparam logic [RANGE_W-1:0] RANGE_FULL_ABV = 4'h5;
  localparam logic [RANGE_W-1:0] RANGE_MAX      = 4'hB;
  localparam logic [RANGE_W-1:0] RANGE_AUTO     = 4'hC;
  localparam logic [RANGE_W-1:0] RANGE_RST      = 4'hC;
  localparam logic               CT_RST         = 1'h1;
  localparam logic [MODE_W-1:0]  MODE_SHUTDOWN  = 2'h0;
  localparam logic [MODE_W-1:0]  MODE_SINGLE    = 2'h1;
  localparam logic [LOSS_W-1:0]  LOSS_NONE      = 2'h0;
  localparam logic [LOSS_W-1:0]  LOSS_ONE       = 2'h1;
  localparam logic [LOSS_W-1:0]  LOSS_TWO       = 2'h2;
  localparam logic [LOSS_W-1:0]  LOSS_THREE     = 2'h3;
  localparam logic [1:0]         RESP_OKAY      = 2'h0;
  localparam logic [1:0]         RESP_SLVERR    = 2'h2;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_RUN  = 1'b1
  } conv_state_t;

  typedef struct packed {
    logic               enable;
    logic [RANGE_W-1:0] range;
  } afe_ctrl_t;

  typedef struct packed {
    logic [RANGE_W-1:0] exponent;
    logic [MANT_W-1:0]  mantissa;
  } result_t;

endpackage

// ---- logic/integration_timer.sv ----
// integration window counter: counts a loaded length, pulses done at its end
// assumes start and abort come from flip-flops on the same clock
`timescale 1ns/1ps
module integration_timer
  import light_conv_pkg::*;
#(
  parameter int unsigned CNT_W = TMR_W
)
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [CNT_W-1:0] length,
  output logic                  busy,
  output logic                  done
);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t q;
  tmr_state_t d;

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    // restart wins over abort: a range step reloads a running window
    if (start)
    begin
      d.busy = 1'b1;
      d.cnt  = length - CNT_W'(1);
    end
    else if (abort)
      d.busy = 1'b0;
    else if (q.busy)
    begin
      if (q.cnt == '0)
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      else
        d.cnt = q.cnt - CNT_W'(1);
    end
    if (!rstn)
      d = '0;
  end

  always_ff @(posedge ref_clk)
    q <= d;

  assign busy = q.busy;
  assign done = q.done;

endmodule

// ---- dv/afe_model.sv ----
// behavioural analog front end: a light level that overloads every range below it
// assumes afe and the level inputs are on ref_clk; outputs are combinational
`timescale 1ns/1ps
module afe_model
  import light_conv_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire afe_ctrl_t          afe,
  input  wire logic [RANGE_W-1:0] light_rng,
  input  wire logic [MANT_W-1:0]  light_mant,
  output logic                    adc_overload,
  output logic [MANT_W-1:0]       adc_mantissa
);
  logic [MANT_W-1:0] idle_pat = 12'h0A5C;

  // a powered-down front end gives no stable mantissa
  always_ff @(posedge ref_clk)
  begin
    idle_pat <= ~idle_pat;
  end

  // overload only while integrating on a range too small for the light
  assign adc_overload = afe.enable && (afe.range < light_rng);
  assign adc_mantissa = afe.enable ? light_mant : idle_pat;
endmodule

// ---- dv/test_light_conversion_control.sv ----
// self-checking bench of the conversion control block over AXI4-Lite
// assumes short integration counts of 20 and 40 cycles and the front-end model
`timescale 1ns/1ps
module test_light_conversion_control;
  import light_conv_pkg::*;
  localparam int unsigned SHORT_C = 20;
  localparam int unsigned LONG_C  = 40;
  localparam logic [11:0] MANT    = 12'h05A3;
  // range, time select and expected loss of each aborted run
  localparam logic [23:0] RNG_TAB = 24'h01_4560;
  localparam logic [5:0]  CT_TAB  = 6'b10_0000;
  localparam logic [11:0] LOSS_TAB = 12'h293;

  logic              ref_clk = 1'b0;
  logic              rstn;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [AXI_AW-1:0] s_axi_awaddr;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [AXI_DW-1:0] s_axi_wdata;
  logic [AXI_SW-1:0] s_axi_wstrb;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [AXI_AW-1:0] s_axi_araddr;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic [AXI_DW-1:0] s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              adc_overload;
  logic [MANT_W-1:0] adc_mantissa;
  afe_ctrl_t         afe;
  logic              irq;
  logic [3:0]        light_rng;
  logic [1:0]        wr_resp;
  logic [AXI_DW-1:0] rd_data;
  logic [1:0]        rd_resp;
  int                err_count = 0;
  int                n_tests = 0;
  int                en_cnt = 0;
  int                t_short;
  int                t_long;

  always #2 ref_clk = ~ref_clk;

  always_ff @(posedge ref_clk)
  begin
    if (afe.enable === 1'b1)
      en_cnt <= en_cnt + 1;
  end

  light_conversion_control #(
    .CYC_SHORT_P (SHORT_C),
    .CYC_LONG_P  (LONG_C)
  ) uut (
    .ref_clk (ref_clk), .rstn (rstn),
    .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
    .s_axi_awaddr (s_axi_awaddr), .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready), .s_axi_wdata (s_axi_wdata),
    .s_axi_wstrb (s_axi_wstrb), .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready), .s_axi_bresp (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid), .s_axi_arready (s_axi_arready),
    .s_axi_araddr (s_axi_araddr), .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready), .s_axi_rdata (s_axi_rdata),
    .s_axi_rresp (s_axi_rresp), .adc_overload (adc_overload),
    .adc_mantissa (adc_mantissa), .afe (afe), .irq (irq)
  );

  afe_model front (
    .ref_clk (ref_clk), .afe (afe), .light_rng (light_rng),
    .light_mant (MANT), .adc_overload (adc_overload), .adc_mantissa (adc_mantissa)
  );

  function automatic logic [31:0] cfg(input logic [3:0] rng, input logic ct,
                                      input logic [1:0] mode, input logic ovf);
    cfg = {16'h0000, rng, ct, mode, ovf, 8'h00};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge ref_clk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge ref_clk);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [AXI_AW-1:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
      @(posedge ref_clk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge ref_clk);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_irq();
    while (irq !== 1'b1)
      @(posedge ref_clk);
  endtask

  // one conversion in the mode given by c, returns the cycles the front end was on until irq
  task automatic run_one(input logic [31:0] c, output int t);
    int e0;
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge ref_clk);
    e0 = en_cnt;
    wr(OFS_CONFIG, c);
    wait_irq();
    t = en_cnt - e0;
  endtask

  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    rstn <= 1'b0;
    s_axi_awvalid <= 1'b0;
    s_axi_awaddr <= 12'h000;
    s_axi_wvalid <= 1'b0;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= 12'h000;
    s_axi_rready <= 1'b0;
    light_rng <= 4'h0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_CONFIG);
    chk("config reset", 32'h0000_C800, rd_data);
    chk("config resp", RESP_OKAY, rd_resp);
    chk("front end off", 32'h0, afe.enable);
    rd(12'h020);
    chk("unmapped resp", RESP_SLVERR, rd_resp);
    wr(12'h020, 32'h0000_0001);
    chk("unmapped wr resp", RESP_SLVERR, wr_resp);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    chk("mask wr resp", RESP_OKAY, wr_resp);
    rd(OFS_IRQ_MASK);
    chk("mask readback", 32'h0000_0001, rd_data);
    // aborted runs: mode readback and resolution loss per range and time
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CONFIG, cfg(RNG_TAB[20-4*i +: 4], CT_TAB[5-i], MODE_SINGLE, 1'b0));
      rd(OFS_CONFIG);
      chk("mode running", MODE_SINGLE, rd_data[10:9]);
      rd(OFS_STATUS);
      chk("loss", {20'h0, RNG_TAB[20-4*i +: 4], 2'b00, LOSS_TAB[10-2*i +: 2], 3'b000, 1'b1},
          rd_data);
      chk("front end range", RNG_TAB[20-4*i +: 4], afe.range);
      wr(OFS_CONFIG, cfg(RNG_TAB[20-4*i +: 4], CT_TAB[5-i], MODE_SHUTDOWN, 1'b0));
    end
    repeat (50) @(posedge ref_clk);
    rd(OFS_IRQ_STAT);
    chk("abort no done", 32'h0, rd_data);
    run_one(cfg(4'h3, 1'b0, MODE_SINGLE, 1'b0), t_short);
    rd(OFS_CONFIG);
    chk("single end", cfg(4'h3, 1'b0, MODE_SHUTDOWN, 1'b0), rd_data);
    chk("front end idle", 32'h0, afe.enable);
    rd(OFS_RESULT);
    chk("result short", {16'h0, 4'h3, MANT}, rd_data);
    run_one(cfg(4'h3, 1'b1, MODE_SINGLE, 1'b0), t_long);
    chk("time diff", LONG_C - SHORT_C, t_long - t_short);
    rd(OFS_RESULT);
    chk("result long", {16'h0, 4'h3, MANT}, rd_data);
    light_rng <= 4'h6;
    run_one(cfg(4'h3, 1'b0, MODE_SINGLE, 1'b0), t_short);
    rd(OFS_CONFIG);
    chk("manual ovf", cfg(4'h3, 1'b0, MODE_SHUTDOWN, 1'b1), rd_data);
    rd(OFS_IRQ_STAT);
    chk("ovf irq", 32'h3, rd_data);
    run_one(cfg(4'h8, 1'b0, MODE_SINGLE, 1'b0), t_short);
    rd(OFS_CONFIG);
    chk("ovf cleared", cfg(4'h8, 1'b0, MODE_SHUTDOWN, 1'b0), rd_data);
    light_rng <= 4'h4;
    run_one(cfg(RANGE_AUTO, 1'b0, MODE_SINGLE, 1'b0), t_short);
    rd(OFS_CONFIG);
    chk("auto no ovf", cfg(RANGE_AUTO, 1'b0, MODE_SHUTDOWN, 1'b0), rd_data);
    rd(OFS_RESULT);
    chk("auto exponent", {16'h0, 4'h4, MANT}, rd_data);
    rd(OFS_IRQ_STAT);
    chk("step irq", 32'h5, rd_data);
    // light beyond every range: steps to the top and flags there
    light_rng <= 4'hF;
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    wr(OFS_CONFIG, cfg(RANGE_AUTO, 1'b0, MODE_SINGLE, 1'b0));
    wait_irq();
    rd(OFS_CONFIG);
    chk("step flag", cfg(RANGE_AUTO, 1'b0, MODE_SINGLE, 1'b1), rd_data);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    wait_irq();
    rd(OFS_CONFIG);
    chk("top ovf", cfg(RANGE_AUTO, 1'b0, MODE_SHUTDOWN, 1'b1), rd_data);
    rd(OFS_RESULT);
    chk("top exponent", {16'h0, RANGE_MAX, MANT}, rd_data);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", 32'h0, irq);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk("irq unmasked", 32'h1, irq);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 32'h0, irq);
    light_rng <= 4'h0;
    for (int m = 2; m < 4; m++)
    begin
      run_one(cfg(4'h3, 1'b0, m[1:0], 1'b0), t_short);
      wr(OFS_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge ref_clk);
      wait_irq();
      rd(OFS_CONFIG);
      chk("continuous", cfg(4'h3, 1'b0, m[1:0], 1'b0), rd_data);
      wr(OFS_CONFIG, cfg(4'h3, 1'b0, MODE_SHUTDOWN, 1'b0));
    end
    tally_and_finish();
  end
endmodule
